// File: design/adc_out_pkg.sv
// Constants for the converter parallel sample output block
// Contract
// - Each sample clock rise starts one conversion
// - Result appears 3.5 sample cycles later
// - Strobe, bits, flag change on falling edge
// - Twelve bits, lowest index is LSB
// - Over-range flag high when input is above or below full scale
// - Output word coded offset binary
package adc_out_pkg;
  localparam int          SAMPLE_W    = 12;
  localparam int          LATENCY_HALF = 7;  // 3.5 cycles in half cycles
  localparam int          PIPE_RISE   = 4;   // Rise stages before fall launch
  localparam logic [11:0] CODE_MID    = 12'h800;
  localparam logic [11:0] CODE_MAX    = 12'hfff;
  localparam logic [11:0] CODE_MIN    = 12'h000;
  localparam logic [12:0] TWOS_OFFSET = 13'h0800;
endpackage : adc_out_pkg

// File: design/adc_parallel_sample_output.sv
// Converter output pipeline: sample on sample clock rise, drive on fall
`timescale 1ns/1ps
module adc_parallel_sample_output
  import adc_out_pkg::*;
(
  input  wire logic                       sys_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       sample_clk,
  input  wire logic signed [adc_out_pkg::SAMPLE_W:0] analog_in,
  output logic [adc_out_pkg::SAMPLE_W-1:0] sample_bits,
  output logic                            overrange_flag,
  output logic                            data_ready_strobe
);
  import adc_out_pkg::*;

  // Elaboration check: coding and clip limits assume a 12-bit word
  if (SAMPLE_W != 12) begin : g_bad_width
    $error("width must be 12");
  end
  // Four rises plus one fall give the half-cycle latency
  if (PIPE_RISE * 2 - 1 != LATENCY_HALF) begin : g_bad_depth
    $error("pipeline depth does not match latency");
  end

  logic                sc_meta_r, sc_sync_r, sc_prev_r;
  logic                sc_meta_nxt, sc_sync_nxt, sc_prev_nxt;
  logic                rise, fall;
  logic [SAMPLE_W-1:0] word_q [PIPE_RISE];
  logic                ovr_q  [PIPE_RISE];
  logic [SAMPLE_W-1:0] word_nxt;
  logic                ovr_nxt;
  logic [SAMPLE_W-1:0] bits_r, bits_nxt;
  logic                ovr_r, ovr_out_nxt, dry_r, dry_nxt;
  logic signed [SAMPLE_W:0] lim_hi, lim_lo;
  logic [SAMPLE_W:0]   shifted;

  // Two-stage sync of sample clock, then edge find
  always_comb begin
    sc_meta_nxt = sample_clk;
    sc_sync_nxt = sc_meta_r;
    sc_prev_nxt = sc_sync_r;
  end
  assign rise = sc_sync_r & ~sc_prev_r;
  assign fall = ~sc_sync_r & sc_prev_r;

  // Quantize: clip to full scale, offset binary
  assign lim_hi  = $signed({1'b0, CODE_MAX}) - $signed(TWOS_OFFSET);
  assign lim_lo  = -$signed(TWOS_OFFSET);
  assign shifted = 13'(analog_in + $signed(TWOS_OFFSET));
  always_comb begin
    ovr_nxt = (analog_in > lim_hi) || (analog_in < lim_lo);
    if (analog_in > lim_hi) begin
      word_nxt = CODE_MAX;
    end else if (analog_in < lim_lo) begin
      word_nxt = CODE_MIN;
    end else begin
      word_nxt = shifted[SAMPLE_W-1:0];
    end
  end

  // Rise pipeline: capture rise plus three more, then fall launch gives 3.5
  genvar g;
  generate
    for (g = 0; g < PIPE_RISE; g++) begin : g_pipe
      if (g == 0) begin : g_first
        // First stage takes the quantized input
        always_ff @(posedge sys_clk) begin
          if (sys_rst) begin
            word_q[g] <= CODE_MID;
            ovr_q[g]  <= 1'b0;
          end else if (rise) begin
            word_q[g] <= word_nxt;
            ovr_q[g]  <= ovr_nxt;
          end
        end
      end else begin : g_next
        // Later stages shift on each detected rise
        always_ff @(posedge sys_clk) begin
          if (sys_rst) begin
            word_q[g] <= CODE_MID;
            ovr_q[g]  <= 1'b0;
          end else if (rise) begin
            word_q[g] <= word_q[g-1];
            ovr_q[g]  <= ovr_q[g-1];
          end
        end
      end
    end
  endgenerate

  // Output stage updates only on falling edge, all together
  always_comb begin
    bits_nxt    = bits_r;
    ovr_out_nxt = ovr_r;
    dry_nxt     = dry_r;
    if (fall) begin
      bits_nxt    = word_q[PIPE_RISE-1];
      ovr_out_nxt = ovr_q[PIPE_RISE-1];
      dry_nxt     = ~dry_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sc_meta_r <= 1'b0;
      sc_sync_r <= 1'b0;
      sc_prev_r <= 1'b0;
      bits_r    <= CODE_MID;
      ovr_r     <= 1'b0;
      dry_r     <= 1'b0;
    end else begin
      sc_meta_r <= sc_meta_nxt;
      sc_sync_r <= sc_sync_nxt;
      sc_prev_r <= sc_prev_nxt;
      bits_r    <= bits_nxt;
      ovr_r     <= ovr_out_nxt;
      dry_r     <= dry_nxt;
    end
  end

  assign sample_bits       = bits_r;
  assign overrange_flag    = ovr_r;
  assign data_ready_strobe = dry_r;
endmodule : adc_parallel_sample_output

// File: sim/adc_out_sva.sv
// Port checks
`timescale 1ns/1ps
module adc_out_sva (input wire logic sys_clk, sys_rst, sample_clk,
  overrange_flag, data_ready_strobe, input wire logic [11:0] sample_bits);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  word_move_a: assert property ($changed({overrange_flag, sample_bits})
    |-> $changed(data_ready_strobe)) else $error("lone");
  fall_edge_a: assert property ($changed(data_ready_strobe)
    |-> !$past(sample_clk, 3)) else $error("early");
  pin_fall_a: assert property ($changed(data_ready_strobe)
    |-> $past(sample_clk, 4)) else $error("strobe without fall");
  strobe_hold_a: assert property ($changed(data_ready_strobe)
    |=> $stable(data_ready_strobe) [*2]) else $error("strobe too short");
  clip_code_a: assert property (overrange_flag
    |-> (sample_bits == 12'hfff) || (sample_bits == 12'h000))
    else $error("overrange word not clipped");
  reset_value_a: assert property (disable iff (1'b0) sys_rst
    |=> (sample_bits == 12'h800) && !overrange_flag && !data_ready_strobe)
    else $error("reset value wrong");
  cover property (overrange_flag);
  cover property (data_ready_strobe);
  cover property ($rose(sample_clk));
  cover property (overrange_flag && (sample_bits == 12'h000));
endmodule : adc_out_sva

// File: sim/capture_model.sv
// Receiver
`timescale 1ns/1ps
module capture_model (input wire logic [12:0] d, input wire logic s,
  output logic [12:0] q);
  always @(s) #1 q = d;
endmodule

// File: sim/tb.sv
// Bench
`timescale 1ns/1ps
module tb;
  logic sys_clk = 0, sys_rst = 1, sample_clk = 0;
  logic overrange_flag, data_ready_strobe;
  logic [11:0] sample_bits;
  logic [12:0] analog_in = '0, word;
  int mismatches = 0, num_checks = 0;
  adc_parallel_sample_output i_dut (.*);
  capture_model i_cap (.d({overrange_flag, sample_bits}),
    .s(data_ready_strobe), .q(word));
  initial forever #20 sys_clk = ~sys_clk;
  initial #7 forever #160 sample_clk = ~sample_clk;
  task check(input logic [12:0] s, e);
    num_checks++;
    mismatches += s !== e;
    if (s !== e) $display("wrong value word exp %h got %h", e, s);
  endtask : check
  task stop_test;
    $display("%0d/%0d", mismatches, num_checks);
    if (!mismatches && num_checks) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task step(input logic [12:0] a, o, e);
    @(negedge sample_clk) @(posedge sys_clk) analog_in <= a;
    #1180 check(word, o);
    @(negedge sample_clk) #240 check(word, e);
  endtask : step
  initial begin
    #50 @(posedge sys_clk) sys_rst <= 0;
    step(13'd2048, 13'h800, 13'h1fff);
    step(-13'd2043, 13'h1fff, 13'h5);
    step(-13'd2049, 13'h0005, 13'h1000);
    stop_test;
  end
  initial #9000 begin check(0, 1); stop_test; end
endmodule
bind adc_parallel_sample_output adc_out_sva i_sva (.*);
